// [adcsf_top.sv]
// Event flag register bank of a multichannel converter, Wishbone slave
// Function
// - Set over flag on above-upper or overflow
// - Over flag sticky until status read
// - Set under flag on below-lower or underrange
// - Under flag sticky until status read
// - Flag bit n belongs to slot n
// - Gain calibration overrange sets bit 7
// - Gain flag clears on read or valid calibration
// - Data-ready is OR of eight unread bits
// - Slot read clears own bit; status read not
// - Every new result sets unread bit again
// - Wait flag: set done, clear read/start
// - Calibration flag: set stored, clear read/start
// - Sequence flag: set iteration, clear read/start/wrap
// - Conversion flag: set result, clear read/start/pre
// - Status register readable at any time
// - Enabled set flag drives interrupt output
// - Enable bits reset to 0x000001
`timescale 1ns/10ps
module adcsf_top
    import adcsf_pkg::*;
(
    input  wire logic           MCLK,       // Core clock, 125 MHz
    input  wire logic           RST_N,      // Asynchronous reset, low
    input  wire logic           WB_CYC_I,   // Bus cycle
    input  wire logic           WB_STB_I,   // Bus strobe
    input  wire logic           WB_WE_I,    // Write enable
    input  wire logic [7:0]     WB_ADR_I,   // Byte address
    input  wire logic [3:0]     WB_SEL_I,   // Byte lanes
    input  wire logic [31:0]    WB_DAT_I,   // Write data
    output logic      [31:0]    WB_DAT_O,   // Read data
    output logic                WB_ACK_O,   // Acknowledge
    input  wire adcsf_result_t  RESULT,     // New slot result
    input  wire adcsf_slot_rd_t SLOT_RD,    // Host slot read
    input  wire adcsf_core_ev_t CORE_EV,    // Core event pulses
    output logic                IRQ,        // Interrupt, high
    output logic                INTERRUPT_OUT_N // Interrupt, low
);

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    logic [23:0] sticky;
    logic [23:0] next_sticky;
    logic [7:0]  unread;
    logic [7:0]  next_unread;
    logic [23:0] enable;
    logic [23:0] next_enable;
    logic [23:0] upper_threshold;
    logic [23:0] next_upper_threshold;
    logic [23:0] lower_threshold;
    logic [23:0] next_lower_threshold;
    logic        ack;
    logic        next_ack;
    logic [31:0] dat;
    logic [31:0] next_dat;

    logic        req;
    logic        rd_req;
    logic        wr_req;
    logic        hit_flags;
    logic        hit_enable;
    logic        hit_upper;
    logic        hit_lower;
    logic        status_rd;
    logic [23:0] lane_mask;
    logic [23:0] wr_bits;
    logic [23:0] flags_view;
    logic [23:0] set_vec;
    logic [23:0] clr_vec;
    logic [7:0]  tor_set;
    logic [7:0]  tur_set;
    logic [7:0]  slot_new;
    logic [7:0]  slot_read;

    // Bus decode
    assign req        = WB_CYC_I & WB_STB_I & ~ack;
    assign rd_req     = req & ~WB_WE_I;
    assign wr_req     = req & WB_WE_I;
    assign hit_flags  = (WB_ADR_I == ADCSF_FLAGS_OFS);
    assign hit_enable = (WB_ADR_I == ADCSF_ENABLE_OFS);
    assign hit_upper  = (WB_ADR_I == ADCSF_UPPER_OFS);
    assign hit_lower  = (WB_ADR_I == ADCSF_LOWER_OFS);
    assign lane_mask  = {{8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}},
                         {8{WB_SEL_I[0]}}};
    assign wr_bits    = WB_DAT_I[23:0] & lane_mask;
    // Clear applies at the edge the read word is captured
    assign status_rd  = rd_req & hit_flags;

    // Per-slot range compare and unread tracking
    genvar gi;
    generate
        for (gi = 0; gi < ADCSF_NSLOT; gi = gi + 1) begin : g_slot
            assign slot_new[gi]  = RESULT.valid
                                   & (RESULT.slot == 3'(gi));
            assign slot_read[gi] = SLOT_RD.rd
                                   & (SLOT_RD.slot == 3'(gi));
            assign tor_set[gi]   = slot_new[gi]
                                   & ((RESULT.value > upper_threshold)
                                   | RESULT.dig_over);
            assign tur_set[gi]   = slot_new[gi]
                                   & ((RESULT.value < lower_threshold)
                                   | RESULT.dig_under);
            // New result wins over a read in the same cycle
            assign next_unread[gi] = (unread[gi] & ~slot_read[gi])
                                     | slot_new[gi];
        end
    endgenerate

    // Data-ready is never stored, only derived
    always_comb begin
        flags_view = sticky;
        flags_view[ADCSF_DRDY_BIT] = |unread;
    end

    // Sticky flag sets and clears
    always_comb begin
        set_vec = 24'h000000;
        clr_vec = 24'h000000;
        set_vec[ADCSF_TOR_LSB +: 8] = tor_set;
        set_vec[ADCSF_TUR_LSB +: 8] = tur_set;
        set_vec[ADCSF_GOR_BIT]  = CORE_EV.gain_cal_done
                                  & CORE_EV.gain_cal_over;
        set_vec[ADCSF_WAIT_BIT] = CORE_EV.wait_done;
        set_vec[ADCSF_CAL_BIT]  = CORE_EV.cal_stored;
        set_vec[ADCSF_SEQ_BIT]  = CORE_EV.seq_iter_done;
        set_vec[ADCSF_CONV_BIT] = RESULT.valid;
        if (status_rd) begin
            clr_vec = ADCSF_STICKY_MASK;
        end
        if (wr_req && hit_flags) begin
            clr_vec = clr_vec | (wr_bits & ADCSF_STICKY_MASK);
        end
        if (CORE_EV.gain_cal_done && !CORE_EV.gain_cal_over) begin
            clr_vec[ADCSF_GOR_BIT] = 1'b1;
        end
        if (CORE_EV.wait_start_wr) begin
            clr_vec[ADCSF_WAIT_BIT] = 1'b1;
        end
        if (CORE_EV.cal_start_wr) begin
            clr_vec[ADCSF_CAL_BIT] = 1'b1;
        end
        if (CORE_EV.sequence_trigger_reg_wr || CORE_EV.seq_wrap) begin
            clr_vec[ADCSF_SEQ_BIT] = 1'b1;
        end
        if (CORE_EV.conversion_trigger_reg_wr || CORE_EV.conv_pre_result) begin
            clr_vec[ADCSF_CONV_BIT] = 1'b1;
        end
        // Set wins over any clear in the same cycle
        next_sticky = ((sticky & ~clr_vec) | set_vec)
                      & ADCSF_STICKY_MASK;
    end

    // Software registers and bus answer
    always_comb begin
        next_enable          = enable;
        next_upper_threshold = upper_threshold;
        next_lower_threshold = lower_threshold;
        next_ack             = req;
        next_dat             = dat;
        if (wr_req) begin
            if (hit_enable) begin
                next_enable = (enable & ~lane_mask) | wr_bits;
            end
            if (hit_upper) begin
                next_upper_threshold = (upper_threshold & ~lane_mask)
                                       | wr_bits;
            end
            if (hit_lower) begin
                next_lower_threshold = (lower_threshold & ~lane_mask)
                                       | wr_bits;
            end
        end
        if (rd_req) begin
            unique case (1'b1)
                hit_flags:  next_dat = {8'h00, flags_view};
                hit_enable: next_dat = {8'h00, enable};
                hit_upper:  next_dat = {8'h00, upper_threshold};
                hit_lower:  next_dat = {8'h00, lower_threshold};
                default:    next_dat = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sticky          <= ADCSF_FLAGS_RST;
            unread          <= ADCSF_UNREAD_RST;
            enable          <= ADCSF_ENABLE_RST;
            upper_threshold <= ADCSF_UPPER_RST;
            lower_threshold <= ADCSF_LOWER_RST;
            ack             <= 1'b0;
            dat             <= ADCSF_DAT_RST;
        end else begin
            sticky          <= next_sticky;
            unread          <= next_unread;
            enable          <= next_enable;
            upper_threshold <= next_upper_threshold;
            lower_threshold <= next_lower_threshold;
            ack             <= next_ack;
            dat             <= next_dat;
        end
    end

    assign WB_ACK_O        = ack;
    assign WB_DAT_O        = dat;
    assign IRQ             = |(flags_view & enable);
    assign INTERRUPT_OUT_N = ~IRQ;

    // Checks
    chk_tor_set_slot: assert property (
        (RESULT.valid && RESULT.value > upper_threshold)
        |=> sticky[ADCSF_TOR_LSB + $past(RESULT.slot)])
        else $error("over flag not set for slot");

    chk_tor_sticky: assert property (
        (sticky[ADCSF_TOR_LSB] && !status_rd
         && !(wr_req && hit_flags))
        |=> sticky[ADCSF_TOR_LSB])
        else $error("over flag dropped without read");

    chk_tur_set_slot: assert property (
        (RESULT.valid && RESULT.dig_under)
        |=> sticky[ADCSF_TUR_LSB + $past(RESULT.slot)])
        else $error("under flag not set on underrange");

    chk_tur_read_clr: assert property (
        (status_rd && !RESULT.valid)
        |=> sticky[ADCSF_TUR_LSB +: 8] == 8'h00)
        else $error("under flags survived status read");

    chk_gor_valid_clr: assert property (
        (CORE_EV.gain_cal_done && !CORE_EV.gain_cal_over)
        |=> !sticky[ADCSF_GOR_BIT])
        else $error("gain flag not cleared by valid calibration");

    chk_gor_set: assert property (
        (CORE_EV.gain_cal_done && CORE_EV.gain_cal_over)
        |=> sticky[ADCSF_GOR_BIT])
        else $error("gain flag not set");

    chk_drdy_or: assert property (
        flags_view[ADCSF_DRDY_BIT] == (unread != 8'h00))
        else $error("data ready not OR of unread bits");

    chk_drdy_status_rd: assert property (
        (status_rd && unread != 8'h00 && !SLOT_RD.rd)
        |=> flags_view[ADCSF_DRDY_BIT])
        else $error("status read cleared data ready");

    chk_unread_reset: assert property (
        (SLOT_RD.rd && RESULT.valid && SLOT_RD.slot == RESULT.slot)
        |=> unread[$past(RESULT.slot)])
        else $error("new result lost to concurrent slot read");

    chk_wait_start_clr: assert property (
        (CORE_EV.wait_start_wr && !CORE_EV.wait_done)
        |=> !sticky[ADCSF_WAIT_BIT])
        else $error("wait flag not cleared by start write");

    chk_cal_set: assert property (
        CORE_EV.cal_stored |=> sticky[ADCSF_CAL_BIT])
        else $error("calibration flag not set");

    chk_seq_wrap_clr: assert property (
        (CORE_EV.seq_wrap && !CORE_EV.seq_iter_done)
        |=> !sticky[ADCSF_SEQ_BIT])
        else $error("sequence flag not cleared on wrap");

    chk_conv_pre_clr: assert property (
        (CORE_EV.conv_pre_result && !RESULT.valid)
        |=> !sticky[ADCSF_CONV_BIT])
        else $error("conversion flag not cleared before result");

    chk_read_answer: assert property (
        (rd_req && hit_flags)
        |=> ack && WB_DAT_O[23:0] == $past(flags_view))
        else $error("status read answer wrong");

    chk_irq_level: assert property (
        INTERRUPT_OUT_N == !((flags_view & enable) != 24'h000000))
        else $error("interrupt output mismatch");

    chk_enable_reset: assert property (
        $rose(RST_N) |-> enable == ADCSF_ENABLE_RST)
        else $error("enable reset value wrong");

    chk_read_keeps_ev: assert property (
        (status_rd && CORE_EV.wait_done)
        |=> sticky[ADCSF_WAIT_BIT])
        else $error("event lost during status read");

    chk_tor_dig_over: assert property (
        (RESULT.valid && RESULT.dig_over)
        |=> sticky[ADCSF_TOR_LSB + $past(RESULT.slot)])
        else $error("over flag not set on overflow");

    chk_tor_read_clr: assert property (
        (status_rd && !RESULT.valid)
        |=> sticky[ADCSF_TOR_LSB +: 8] == 8'h00)
        else $error("over flags survived status read");

    chk_tur_below: assert property (
        (RESULT.valid && RESULT.value < lower_threshold)
        |=> sticky[ADCSF_TUR_LSB + $past(RESULT.slot)])
        else $error("under flag not set for slot");

    chk_tur_sticky: assert property (
        (sticky[ADCSF_TUR_LSB] && !status_rd && !(wr_req && hit_flags))
        |=> sticky[ADCSF_TUR_LSB])
        else $error("under flag dropped without read");

    chk_tor_no_cause: assert property (
        (!status_rd && !(wr_req && hit_flags)
         && (!RESULT.valid
             || (!RESULT.dig_over && RESULT.value <= upper_threshold)))
        |=> $stable(sticky[ADCSF_TOR_LSB +: 8]))
        else $error("over flag changed without cause");

    chk_gor_read_clr: assert property (
        (status_rd && !(CORE_EV.gain_cal_done && CORE_EV.gain_cal_over))
        |=> !sticky[ADCSF_GOR_BIT])
        else $error("gain flag survived status read");

    chk_unread_set: assert property (
        RESULT.valid
        |=> unread[$past(RESULT.slot)])
        else $error("unread bit not set by new result");

    chk_slot_rd_clr: assert property (
        (SLOT_RD.rd && !(RESULT.valid && RESULT.slot == SLOT_RD.slot))
        |=> !unread[$past(SLOT_RD.slot)])
        else $error("slot read did not clear unread bit");

    chk_wait_set: assert property (
        CORE_EV.wait_done
        |=> sticky[ADCSF_WAIT_BIT])
        else $error("wait flag not set");

    chk_cal_start_clr: assert property (
        (CORE_EV.cal_start_wr && !CORE_EV.cal_stored)
        |=> !sticky[ADCSF_CAL_BIT])
        else $error("calibration flag not cleared by start write");

    chk_seq_set: assert property (
        CORE_EV.seq_iter_done
        |=> sticky[ADCSF_SEQ_BIT])
        else $error("sequence flag not set");

    chk_sequence_trigger_reg_clr: assert property (
        (CORE_EV.sequence_trigger_reg_wr && !CORE_EV.seq_iter_done)
        |=> !sticky[ADCSF_SEQ_BIT])
        else $error("sequence flag not cleared by start write");

    chk_conv_set: assert property (
        RESULT.valid
        |=> sticky[ADCSF_CONV_BIT])
        else $error("conversion flag not set");

    chk_conversion_trigger_reg_clr: assert property (
        (CORE_EV.conversion_trigger_reg_wr && !RESULT.valid)
        |=> !sticky[ADCSF_CONV_BIT])
        else $error("conversion flag not cleared by start write");

    chk_bus_answer: assert property (
        (WB_CYC_I && WB_STB_I && !ack)
        |=> WB_ACK_O)
        else $error("bus request not answered");

    chk_ack_single: assert property (
        WB_ACK_O
        |=> !WB_ACK_O)
        else $error("acknowledge longer than one cycle");

    chk_irq_masked: assert property (
        (enable == 24'h000000)
        |-> !IRQ && INTERRUPT_OUT_N)
        else $error("interrupt raised while all sources masked");

endmodule

// [adcsf_pkg.sv]
// Package for the converter event flag register bank
package adcsf_pkg;

    // Register byte addresses on the Wishbone bus
    localparam logic [7:0]  ADCSF_FLAGS_OFS  = 8'h38;
    localparam logic [7:0]  ADCSF_ENABLE_OFS = 8'h3C;
    localparam logic [7:0]  ADCSF_UPPER_OFS  = 8'h40;
    localparam logic [7:0]  ADCSF_LOWER_OFS  = 8'h44;

    // Widths and counts
    localparam int          ADCSF_NSLOT      = 8;
    localparam int          ADCSF_FLAGS_W    = 24;

    // Field positions inside event_flags and event_enable_reg
    localparam int          ADCSF_TOR_LSB    = 16;
    localparam int          ADCSF_TUR_LSB    = 8;
    localparam int          ADCSF_GOR_BIT    = 7;
    localparam int          ADCSF_DRDY_BIT   = 4;
    localparam int          ADCSF_WAIT_BIT   = 3;
    localparam int          ADCSF_CAL_BIT    = 2;
    localparam int          ADCSF_SEQ_BIT    = 1;
    localparam int          ADCSF_CONV_BIT   = 0;

    // Sticky bits that exist (bits 6:4 are not sticky storage)
    localparam logic [23:0] ADCSF_STICKY_MASK = 24'hFFFF8F;

    // Values after reset
    localparam logic [23:0] ADCSF_FLAGS_RST  = 24'h000000;
    localparam logic [23:0] ADCSF_ENABLE_RST = 24'h000001;
    localparam logic [23:0] ADCSF_UPPER_RST  = 24'hFFFFFF;
    localparam logic [23:0] ADCSF_LOWER_RST  = 24'h000000;
    localparam logic [7:0]  ADCSF_UNREAD_RST = 8'h00;
    localparam logic [31:0] ADCSF_DAT_RST    = 32'h00000000;

    // A new result written into one slot
    typedef struct packed {
        logic        valid;
        logic [2:0]  slot;
        logic [23:0] value;
        logic        dig_over;
        logic        dig_under;
    } adcsf_result_t;

    // Host read of one result slot
    typedef struct packed {
        logic        rd;
        logic [2:0]  slot;
    } adcsf_slot_rd_t;

    // One-cycle event pulses from the converter core
    typedef struct packed {
        logic        wait_done;
        logic        wait_start_wr;
        logic        cal_stored;
        logic        cal_start_wr;
        logic        gain_cal_done;
        logic        gain_cal_over;
        logic        seq_iter_done;
        logic        sequence_trigger_reg_wr;
        logic        seq_wrap;
        logic        conversion_trigger_reg_wr;
        logic        conv_pre_result;
    } adcsf_core_ev_t;

endpackage

// [adcsf_core_model.sv]
// Converter core model: result, slot read and event pulses
`timescale 1ns/10ps
module adcsf_core_model
    import adcsf_pkg::*;
(
    input  wire logic MCLK,    // Core clock
    output adcsf_result_t  RESULT,  // Result pulse
    output adcsf_slot_rd_t SLOT_RD, // Slot read pulse
    output adcsf_core_ev_t CORE_EV  // Event pulses
);
    initial begin
        RESULT = '0;
        SLOT_RD = '0;
        CORE_EV = '0;
    end

    // Each pulse lasts one cycle, launched after an edge
    task automatic result(input logic [2:0] s, input logic [23:0] v,
                          input logic ov, input logic un);
        @(posedge MCLK);
        RESULT <= '{1'b1, s, v, ov, un};
        @(posedge MCLK);
        RESULT <= '0;
    endtask

    task automatic slot_read(input logic [2:0] s);
        @(posedge MCLK);
        SLOT_RD <= '{1'b1, s};
        @(posedge MCLK);
        SLOT_RD <= '0;
    endtask

    task automatic ev(input adcsf_core_ev_t e);
        @(posedge MCLK);
        CORE_EV <= e;
        @(posedge MCLK);
        CORE_EV <= '0;
    endtask
endmodule

// [testbench.sv]
// Self-checking testbench for the converter event flag bank
`timescale 1ns/10ps
module testbench
    import adcsf_pkg::*;
;
    logic           mclk = 1'b0;
    logic           rst_n = 1'b0;
    logic           cyc = 1'b0;
    logic           stb = 1'b0;
    logic           we = 1'b0;
    logic [7:0]     adr = 8'h00;
    logic [3:0]     sel = 4'hF;
    logic [3:0]     lanes = 4'hF;
    logic [31:0]    wdat = 32'h0;
    logic [31:0]    rdat;
    logic           ack;
    logic           irq;
    logic           int_n;
    adcsf_result_t  res;
    adcsf_slot_rd_t srd;
    adcsf_core_ev_t cev;
    int             error_cnt = 0;
    int             num_checks = 0;
    int             cycles = 0;

    always #4 mclk = ~mclk;

    adcsf_top i_dut (.MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .RESULT(res),
        .SLOT_RD(srd), .CORE_EV(cev), .IRQ(irq), .INTERRUPT_OUT_N(int_n));

    adcsf_core_model i_core (.MCLK(mclk), .RESULT(res), .SLOT_RD(srd),
        .CORE_EV(cev));

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Ack is sampled at the edge, before that edge's updates land
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lanes;
        wdat <= d;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("bus_ack_wait", 32'h2, n);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e,
                         input string nm);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic irqchk(input logic on);
        @(negedge mclk);
        chk("irq_pins", {30'h0, on, ~on}, {30'h0, irq, int_n});
    endtask

    task automatic t_reset();
        rdchk(ADCSF_FLAGS_OFS, 32'h0, "flags_rst");
        rdchk(ADCSF_ENABLE_OFS, 32'h000001, "enable_rst");
        rdchk(ADCSF_UPPER_OFS, 32'hFFFFFF, "upper_rst");
        rdchk(ADCSF_LOWER_OFS, 32'h0, "lower_rst");
        rdchk(8'h50, 32'h0, "unmapped");
        irqchk(1'b0);
    endtask

    task automatic ev_case(input adcsf_core_ev_t s,
                           input adcsf_core_ev_t c, input int b);
        i_core.ev(s);
        rdchk(ADCSF_FLAGS_OFS, 32'h1 << b, "flag_set");
        rdchk(ADCSF_FLAGS_OFS, 32'h0, "read_clear");
        i_core.ev(s);
        i_core.ev(c);
        rdchk(ADCSF_FLAGS_OFS, 32'h0, "event_clear");
    endtask

    task automatic t_events();
        ev_case('{wait_done:1'b1, default:1'b0},
                '{wait_start_wr:1'b1, default:1'b0}, 3);
        ev_case('{cal_stored:1'b1, default:1'b0},
                '{cal_start_wr:1'b1, default:1'b0}, 2);
        ev_case('{seq_iter_done:1'b1, default:1'b0},
                '{sequence_trigger_reg_wr:1'b1, default:1'b0}, 1);
        ev_case('{seq_iter_done:1'b1, default:1'b0},
                '{seq_wrap:1'b1, default:1'b0}, 1);
        ev_case('{gain_cal_done:1'b1, gain_cal_over:1'b1,
                  default:1'b0}, '{gain_cal_done:1'b1, default:1'b0}, 7);
    endtask

    task automatic t_irq();
        i_core.result(3'd1, 24'h20, 1'b0, 1'b0);
        irqchk(1'b1);
        wr(ADCSF_ENABLE_OFS, 32'h0);
        irqchk(1'b0);
        wr(ADCSF_ENABLE_OFS, 32'h8);
        i_core.ev('{wait_done:1'b1, default:1'b0});
        irqchk(1'b1);
        wr(ADCSF_FLAGS_OFS, 32'h8);
        irqchk(1'b0);
        rdchk(ADCSF_FLAGS_OFS, 32'h11, "flags_w1c");
        i_core.slot_read(3'd1);
    endtask

    task automatic t_range();
        wr(ADCSF_UPPER_OFS, 32'h100);
        lanes = 4'h1;
        wr(ADCSF_UPPER_OFS, 32'hABCDEF);
        lanes = 4'hF;
        wr(ADCSF_LOWER_OFS, 32'h10);
        rdchk(ADCSF_UPPER_OFS, 32'h1EF, "upper_rw");
        i_core.result(3'd3, 24'h200, 1'b0, 1'b0);
        i_core.result(3'd3, 24'h80, 1'b0, 1'b0);
        i_core.result(3'd5, 24'h5, 1'b0, 1'b0);
        i_core.result(3'd0, 24'h50, 1'b1, 1'b0);
        i_core.result(3'd7, 24'h50, 1'b0, 1'b1);
        rdchk(ADCSF_FLAGS_OFS, 32'h09A011, "range_flags");
        rdchk(ADCSF_FLAGS_OFS, 32'h10, "range_cleared");
    endtask

    task automatic t_ready();
        i_core.slot_read(3'd0);
        i_core.slot_read(3'd3);
        i_core.slot_read(3'd5);
        rdchk(ADCSF_FLAGS_OFS, 32'h10, "one_unread");
        i_core.result(3'd2, 24'h50, 1'b0, 1'b0);
        i_core.ev('{conv_pre_result:1'b1, default:1'b0});
        rdchk(ADCSF_FLAGS_OFS, 32'h10, "conv_pre");
        i_core.result(3'd2, 24'h50, 1'b0, 1'b0);
        i_core.ev('{conversion_trigger_reg_wr:1'b1, default:1'b0});
        rdchk(ADCSF_FLAGS_OFS, 32'h10, "conversion_trigger_reg");
        i_core.slot_read(3'd7);
        i_core.slot_read(3'd2);
        rdchk(ADCSF_FLAGS_OFS, 32'h0, "all_read");
        i_core.result(3'd7, 24'h50, 1'b0, 1'b0);
        rdchk(ADCSF_FLAGS_OFS, 32'h11, "ready_again");
        fork
            i_core.result(3'd6, 24'h50, 1'b0, 1'b0);
            i_core.slot_read(3'd6);
        join
        rdchk(ADCSF_FLAGS_OFS, 32'h11, "read_race");
        i_core.slot_read(3'd7);
        i_core.slot_read(3'd6);
        rdchk(ADCSF_FLAGS_OFS, 32'h0, "drained");
    endtask

    task automatic t_concurrent();
        logic [31:0] q;
        i_core.ev('{wait_done:1'b1, default:1'b0});
        fork
            xfer(1'b0, ADCSF_FLAGS_OFS, 32'h0, q);
            i_core.ev('{cal_stored:1'b1, default:1'b0});
        join
        chk("snapshot", 32'h8, q);
        rdchk(ADCSF_FLAGS_OFS, 32'h4, "event_kept");
    endtask

    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_events();
        t_irq();
        t_range();
        t_ready();
        t_concurrent();
        final_report();
    end
endmodule
